// >>> src/scg_pkg.sv
// Constants and types for the sleep-mode clock gating block
package scg_pkg;
   // ------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] OFS_RUN   = 12'h100;
   localparam logic [11:0] OFS_SLEEP = 12'h110;
   localparam logic [11:0] OFS_DEEP  = 12'h120;
   localparam logic [11:0] OFS_CFG   = 12'h060;
   // ------------------------------------------------------------
   // Field layout
   // ------------------------------------------------------------
   localparam int          BIT_WDT   = 3;
   localparam int          BIT_HIB   = 6;
   localparam int          SPD_LSB   = 8;
   localparam int          BIT_ADC   = 16;
   localparam int          BIT_PWM   = 20;
   localparam int          BIT_CAN   = 24;
   localparam int          BIT_AUTO  = 0;
   localparam int          N_UNITS   = 5;
   // Unit index order on the enable and fault vectors
   localparam int          U_WDT     = 0;
   localparam int          U_HIB     = 1;
   localparam int          U_ADC     = 2;
   localparam int          U_PWM     = 3;
   localparam int          U_CAN     = 4;
   // ------------------------------------------------------------
   // Reset values and writable masks
   // ------------------------------------------------------------
   localparam logic [31:0] GATE_RST  = 32'h0000_0040;
   localparam logic [31:0] GATE_MASK = 32'h0111_0348;
   localparam logic [31:0] CFG_RST   = 32'h0000_0000;
   localparam logic [31:0] CFG_MASK  = 32'h0000_0001;
   localparam logic [1:0]  SPD_1M    = 2'h3;
   localparam logic [1:0]  SPD_125K  = 2'h0;
   typedef enum logic [1:0] {PM_RUN, PM_SLEEP, PM_DEEP} scg_mode_t;
endpackage

// >>> src/scg_top.sv
// Clock gating control registers with bus fault check for gated units
// Summary of operation
// - Each gating bit is the clock enable of one peripheral unit.
// - Access to a gated-off peripheral is answered with a bus fault.
// - Gating bits reset to zero except the documented hibernation bit.
// - Run, sleep and deep-sleep registers apply in their own modes.
// - Sleep registers apply only when automatic gating select is set.
// - Bits 9:8 pick converter rate: 3=1M, 2=500K, 1=250K, 0=125K.
// - Converter rate never exceeds the part maximum, whatever is written.
// - Bit 6 gates the low-power hibernation module clock.
// - Bit 3 gates the watchdog; gated-off watchdog access faults.
// - Reserved bits read zero and ignore writes; software preserves them.
// - Sleep gating register at 0x110, read/write, reset 0x00000040.
// - Bits 24, 20, 16 gate CAN, motor PWM and converter clocks.
`timescale 1ns/10ps
`default_nettype none
module scg_top #(
   parameter logic [1:0] MAX_SPEED = scg_pkg::SPD_1M
) (
   input  wire logic        CLK,
   input  wire logic        SRST,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [11:0] WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   output logic             WB_ERR_O,
   input  wire logic        SLEEP_REQ,
   input  wire logic        DEEP_REQ,
   input  wire logic [4:0]  PERIPH_ACC,
   output logic      [4:0]  PERIPH_FAULT,
   output logic      [4:0]  UNIT_CLK_EN,
   output logic      [1:0]  CONV_SPEED,
   output logic      [1:0]  POWER_MODE
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [4:0] unit_en(input logic [31:0] r);
      unit_en[scg_pkg::U_WDT] = r[scg_pkg::BIT_WDT];
      unit_en[scg_pkg::U_HIB] = r[scg_pkg::BIT_HIB];
      unit_en[scg_pkg::U_ADC] = r[scg_pkg::BIT_ADC];
      unit_en[scg_pkg::U_PWM] = r[scg_pkg::BIT_PWM];
      unit_en[scg_pkg::U_CAN] = r[scg_pkg::BIT_CAN];
   endfunction

   // Byte-lane merge, then keep only writable bits
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] msk);
      logic [31:0] v;
      v = old;
      for (int i = 0; i < 4; i++) begin
         if (WB_SEL_I[i]) begin
            v[i*8 +: 8] = WB_DAT_I[i*8 +: 8];
         end
      end
      merge = v & msk;
   endfunction

   // ------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------
   logic [31:0] run_reg, run_next;
   logic [31:0] sleep_reg, sleep_next;
   logic [31:0] deep_reg, deep_next;
   logic [31:0] cfg_reg, cfg_next;
   logic [31:0] dat_reg, dat_next;
   logic        ack_reg, ack_next;
   logic        err_reg, err_next;
   logic        req;
   logic        hit;
   logic [31:0] wr_val;

   assign req = WB_CYC_I & WB_STB_I & ~ack_reg & ~err_reg;

   always_comb begin
      run_next   = run_reg;
      sleep_next = sleep_reg;
      deep_next  = deep_reg;
      cfg_next   = cfg_reg;
      dat_next   = 32'h0000_0000;
      hit        = 1'b1;
      wr_val     = 32'h0000_0000;
      case (WB_ADR_I)
         scg_pkg::OFS_RUN:   dat_next = run_reg;
         scg_pkg::OFS_SLEEP: dat_next = sleep_reg;
         scg_pkg::OFS_DEEP:  dat_next = deep_reg;
         scg_pkg::OFS_CFG:   dat_next = cfg_reg;
         default:            hit = 1'b0;
      endcase
      if (req && WB_WE_I && hit) begin
         if (WB_ADR_I == scg_pkg::OFS_CFG) begin
            cfg_next = merge(cfg_reg, scg_pkg::CFG_MASK);
         end else begin
            wr_val = merge(WB_ADR_I == scg_pkg::OFS_RUN ? run_reg :
                           WB_ADR_I == scg_pkg::OFS_SLEEP ? sleep_reg : deep_reg,
                           scg_pkg::GATE_MASK);
            // clamp rate to the part maximum
            if (wr_val[scg_pkg::SPD_LSB +: 2] > MAX_SPEED) begin
               wr_val[scg_pkg::SPD_LSB +: 2] = MAX_SPEED;
            end
            case (WB_ADR_I)
               scg_pkg::OFS_RUN:   run_next = wr_val;
               scg_pkg::OFS_SLEEP: sleep_next = wr_val;
               default:            deep_next = wr_val;
            endcase
         end
      end
      if (!(req && !WB_WE_I && hit)) begin
         dat_next = 32'h0000_0000;
      end
      ack_next = req & hit;
      err_next = req & ~hit;
   end

   always_ff @(posedge CLK) begin
      // gating bits reset to zero but hibernation
      if (SRST) begin
         run_reg   <= scg_pkg::GATE_RST;
         sleep_reg <= scg_pkg::GATE_RST;
         deep_reg  <= scg_pkg::GATE_RST;
         cfg_reg   <= scg_pkg::CFG_RST;
         dat_reg   <= 32'h0000_0000;
         ack_reg   <= 1'b0;
         err_reg   <= 1'b0;
      end else begin
         run_reg   <= run_next;
         sleep_reg <= sleep_next;
         deep_reg  <= deep_next;
         cfg_reg   <= cfg_next;
         dat_reg   <= dat_next;
         ack_reg   <= ack_next;
         err_reg   <= err_next;
      end
   end

   assign WB_DAT_O = dat_reg;
   assign WB_ACK_O = ack_reg;
   assign WB_ERR_O = err_reg;

   // ------------------------------------------------------------
   // Mode selection and gating
   // ------------------------------------------------------------
   scg_pkg::scg_mode_t mode_reg, mode_next;
   logic [31:0] sel_word;
   logic [4:0]  en_reg, en_next;
   logic [1:0]  spd_reg, spd_next;
   logic [4:0]  flt_reg, flt_next;

   always_comb begin
      // Deep sleep outranks sleep when both are requested
      if (DEEP_REQ) begin
         mode_next = scg_pkg::PM_DEEP;
      end else if (SLEEP_REQ) begin
         mode_next = scg_pkg::PM_SLEEP;
      end else begin
         mode_next = scg_pkg::PM_RUN;
      end
      // sleep registers only under automatic gating
      case (mode_reg)
         scg_pkg::PM_SLEEP: sel_word = cfg_reg[scg_pkg::BIT_AUTO] ? sleep_reg : run_reg;
         scg_pkg::PM_DEEP:  sel_word = cfg_reg[scg_pkg::BIT_AUTO] ? deep_reg : run_reg;
         default:           sel_word = run_reg;
      endcase
      // watchdog bit 3, hibernation bit 6, bits 24, 20, 16
      en_next  = unit_en(sel_word);
      // rate code passes straight to the converter
      spd_next = sel_word[scg_pkg::SPD_LSB +: 2];
      // fault on access to a stopped unit
      flt_next = PERIPH_ACC & ~en_reg;
   end

   // Enables leave a flop so the downstream gate cell sees one clean edge
   always_ff @(posedge CLK) begin
      if (SRST) begin
         mode_reg <= scg_pkg::PM_RUN;
         en_reg   <= unit_en(scg_pkg::GATE_RST);
         spd_reg  <= scg_pkg::SPD_125K;
         flt_reg  <= 5'h00;
      end else begin
         mode_reg <= mode_next;
         en_reg   <= en_next;
         spd_reg  <= spd_next;
         flt_reg  <= flt_next;
      end
   end

   assign UNIT_CLK_EN  = en_reg;
   assign CONV_SPEED   = spd_reg;
   assign PERIPH_FAULT = flt_reg;
   assign POWER_MODE   = mode_reg;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   a_enable_follows_word: assert property (
      ##1 UNIT_CLK_EN == unit_en($past(sel_word)))
      else $error("Unit enable does not follow selected word");
   a_fault_when_gated: assert property (
      (PERIPH_ACC[0] && !UNIT_CLK_EN[0]) |=> PERIPH_FAULT[0])
      else $error("Gated watchdog access did not fault");
   a_no_fault_open: assert property (
      (PERIPH_ACC == 5'h00) |=> PERIPH_FAULT == 5'h00)
      else $error("Fault without an access");
   a_reset_values: assert property (
      @(posedge CLK) disable iff (1'b0) $past(SRST) |-> sleep_reg == scg_pkg::GATE_RST && UNIT_CLK_EN == 5'h02)
      else $error("Reset value wrong");
   a_run_when_no_auto: assert property (
      !cfg_reg[scg_pkg::BIT_AUTO] |-> sel_word == run_reg)
      else $error("Sleep word used without automatic gating");
   a_deep_word_used: assert property (
      (mode_reg == scg_pkg::PM_DEEP && cfg_reg[scg_pkg::BIT_AUTO]) |-> sel_word == deep_reg)
      else $error("Deep word not applied in deep sleep");
   a_speed_capped: assert property (
      CONV_SPEED <= MAX_SPEED && sleep_reg[9:8] <= MAX_SPEED)
      else $error("Converter rate above maximum");
   a_reserved_zero: assert property (
      ((run_reg | sleep_reg | deep_reg) & ~scg_pkg::GATE_MASK) == 32'h0000_0000)
      else $error("Reserved bit set");
   a_sleep_write: assert property (
      (req && WB_WE_I && WB_ADR_I == scg_pkg::OFS_SLEEP && WB_SEL_I == 4'hF
       && WB_DAT_I[9:8] <= MAX_SPEED) |=> sleep_reg == ($past(WB_DAT_I) & scg_pkg::GATE_MASK))
      else $error("Sleep register write lost");
   a_ack_one_cycle: assert property (
      WB_ACK_O |=> !WB_ACK_O)
      else $error("Ack held longer than one cycle");
   a_gate_latency: assert property (
      (req && WB_WE_I && WB_ADR_I == scg_pkg::OFS_RUN && mode_reg == scg_pkg::PM_RUN
       && mode_next == scg_pkg::PM_RUN) |=> ##1 UNIT_CLK_EN == unit_en($past(run_reg)))
      else $error("Enable late after write");
   a_hib_bit: assert property (
      UNIT_CLK_EN[scg_pkg::U_HIB] == $past(sel_word[scg_pkg::BIT_HIB]))
      else $error("Hibernation gate mismatch");
   a_can_bit: assert property (
      UNIT_CLK_EN[scg_pkg::U_CAN] == $past(sel_word[scg_pkg::BIT_CAN]))
      else $error("CAN gate mismatch");
   a_speed_code: assert property (
      CONV_SPEED == $past(sel_word[9:8]))
      else $error("Rate code not applied");
   a_wdt_bit: assert property (
      UNIT_CLK_EN[scg_pkg::U_WDT] == $past(sel_word[scg_pkg::BIT_WDT]))
      else $error("Watchdog gate mismatch");
   a_pwm_bit: assert property (
      UNIT_CLK_EN[scg_pkg::U_PWM] == $past(sel_word[scg_pkg::BIT_PWM]))
      else $error("PWM gate mismatch");
   a_adc_bit: assert property (
      UNIT_CLK_EN[scg_pkg::U_ADC] == $past(sel_word[scg_pkg::BIT_ADC]))
      else $error("Converter gate mismatch");
   a_fault_exact: assert property (
      PERIPH_FAULT == $past(PERIPH_ACC & ~UNIT_CLK_EN))
      else $error("Fault pulse does not match gated accesses");
   a_no_fault_clocked: assert property (
      (PERIPH_ACC[scg_pkg::U_CAN] && UNIT_CLK_EN[scg_pkg::U_CAN]) |=> !PERIPH_FAULT[scg_pkg::U_CAN])
      else $error("Fault on a clocked unit");

   // ------------------------------------------------------------
   // Power mode checks
   // ------------------------------------------------------------
   a_deep_wins: assert property (
      DEEP_REQ |=> POWER_MODE == scg_pkg::PM_DEEP)
      else $error("Deep sleep request not taken");
   a_sleep_mode: assert property (
      (SLEEP_REQ && !DEEP_REQ) |=> POWER_MODE == scg_pkg::PM_SLEEP)
      else $error("Sleep request not taken");
   a_run_mode: assert property (
      (!SLEEP_REQ && !DEEP_REQ) |=> POWER_MODE == scg_pkg::PM_RUN)
      else $error("Run mode not restored");
   a_sleep_word_used: assert property (
      (mode_reg == scg_pkg::PM_SLEEP && cfg_reg[scg_pkg::BIT_AUTO]) |-> sel_word == sleep_reg)
      else $error("Sleep word not applied in sleep");

   // ------------------------------------------------------------
   // Bus answer checks
   // ------------------------------------------------------------
   a_err_one_cycle: assert property (
      WB_ERR_O |=> !WB_ERR_O)
      else $error("Error held longer than one cycle");
   a_ack_err_apart: assert property (
      !(WB_ACK_O && WB_ERR_O))
      else $error("Ack and error together");
   a_unmapped_no_store: assert property (
      WB_ERR_O |-> $stable(run_reg) && $stable(sleep_reg) && $stable(deep_reg) && $stable(cfg_reg))
      else $error("Unmapped access changed a register");
   a_idle_data_zero: assert property (
      !WB_ACK_O |-> WB_DAT_O == 32'h0000_0000)
      else $error("Read data outside an ack");

   c_sleep_auto: cover property (mode_reg == scg_pkg::PM_SLEEP && cfg_reg[scg_pkg::BIT_AUTO]);
   c_deep_auto: cover property (mode_reg == scg_pkg::PM_DEEP && cfg_reg[scg_pkg::BIT_AUTO]);
   c_fault: cover property (PERIPH_FAULT != 5'h00);
   c_unmapped: cover property (WB_ERR_O);
   c_speed_clamp: cover property (req && WB_WE_I && WB_DAT_I[9:8] > MAX_SPEED);
endmodule
`default_nettype wire

// >>> tb/scg_top_bench.sv
// Self-checking bench for the clock gating control block
`timescale 1ns/10ps
`default_nettype none
module scg_top_bench;
   logic        clk      = 1'b0;
   logic        srst     = 1'b1;
   logic        cyc      = 1'b0;
   logic        stb      = 1'b0;
   logic        we       = 1'b0;
   logic [11:0] adr      = 12'h000;
   logic [3:0]  sel      = 4'h0;
   logic [31:0] wdat     = 32'h0000_0000;
   logic        slp      = 1'b0;
   logic        dp       = 1'b0;
   logic [4:0]  acc      = 5'h00;
   logic [31:0] rdat;
   logic        ack;
   logic        err;
   logic [4:0]  fault;
   logic [4:0]  clk_en;
   logic [1:0]  speed;
   logic [1:0]  pmode;
   logic [31:0] q;
   logic        e;
   int          n_errors = 0;
   int          compares = 0;
   int          ub [5]   = '{scg_pkg::BIT_WDT, scg_pkg::BIT_HIB, scg_pkg::BIT_ADC, scg_pkg::BIT_PWM, scg_pkg::BIT_CAN};
   logic [11:0] ofs [3]  = '{scg_pkg::OFS_RUN, scg_pkg::OFS_SLEEP, scg_pkg::OFS_DEEP};

   always #5 clk = ~clk;

   // Rate ceiling below the top code so the clamp is exercised
   scg_top #(.MAX_SPEED(2'h2)) i_scg_top (
      .CLK(clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .WB_ERR_O(err),
      .SLEEP_REQ(slp), .DEEP_REQ(dp), .PERIPH_ACC(acc), .PERIPH_FAULT(fault),
      .UNIT_CLK_EN(clk_en), .CONV_SPEED(speed), .POWER_MODE(pmode));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task tally_and_finish;
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Request held until ack or err is sampled high
   task automatic wb(input logic w, input logic [11:0] a, input logic [3:0] s, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
      q = rdat;
      e = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 50) begin
         n_errors++;
         tally_and_finish();
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      wb(1'b1, a, 4'hF, d);
   endtask

   task automatic rd(input logic [11:0] a);
      wb(1'b0, a, 4'hF, 32'h0000_0000);
   endtask

   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      chk("clk_en", clk_en, 32'h0000_0002);
      chk("speed", speed, 32'h0000_0000);
      for (int k = 0; k < 3; k++) begin
         rd(ofs[k]);
         chk("reset word", q, scg_pkg::GATE_RST);
      end
      wr(scg_pkg::OFS_SLEEP, 32'hFFFF_FFFF);
      rd(scg_pkg::OFS_SLEEP);
      chk("sleep word", q, 32'h0111_0248);
      wb(1'b1, scg_pkg::OFS_RUN, 4'h2, 32'hFFFF_FFFF);
      rd(scg_pkg::OFS_RUN);
      chk("lane write", q, 32'h0000_0240);
      rd(12'h004);
      chk("unmapped err", e, 32'h0000_0001);
      chk("unmapped data", q, 32'h0000_0000);
      // Each unit alone enabled, every unit accessed
      for (int j = 0; j < 5; j++) begin
         wr(scg_pkg::OFS_RUN, 32'h1 << ub[j]);
         settle();
         chk("unit enable", clk_en, 32'h1 << j);
         for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            acc <= 5'h01 << i;
            @(posedge clk);
            acc <= 5'h00;
            #1;
            chk("fault", fault, (i == j) ? 32'h0 : (32'h1 << i));
         end
      end
      for (int v = 0; v < 4; v++) begin
         wr(scg_pkg::OFS_RUN, v << 8);
         settle();
         chk("conv speed", speed, (v > 2) ? 2 : v);
         rd(scg_pkg::OFS_RUN);
         chk("speed field", q, ((v > 2) ? 2 : v) << 8);
      end
      wr(scg_pkg::OFS_RUN, 32'h1 << scg_pkg::BIT_HIB);
      wr(scg_pkg::OFS_SLEEP, 32'h1 << scg_pkg::BIT_CAN);
      wr(scg_pkg::OFS_DEEP, 32'h1 << scg_pkg::BIT_WDT);
      @(posedge clk);
      slp <= 1'b1;
      settle();
      chk("mode", pmode, 32'h1);
      chk("no auto", clk_en, 32'h0000_0002);
      wr(scg_pkg::OFS_CFG, 32'h0000_0001);
      settle();
      chk("sleep en", clk_en, 32'h0000_0010);
      @(posedge clk);
      dp <= 1'b1;
      settle();
      chk("deep mode", pmode, 32'h2);
      chk("deep en", clk_en, 32'h0000_0001);
      @(posedge clk);
      slp <= 1'b0;
      dp <= 1'b0;
      settle();
      chk("run en", clk_en, 32'h0000_0002);
      @(posedge clk);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      rd(scg_pkg::OFS_RUN);
      chk("second reset", q, scg_pkg::GATE_RST);
      tally_and_finish();
   end
endmodule
`default_nettype wire
